// >>> design/uart_baud_and_pin_routing.sv
// Serial channel baud generation, pin routing, simple frames and APB registers.
//
// Contract
// - Bit rate is one over overflow period times two times the division factor.
// - Timer overflow period is compare value plus one timer clocks.
// - Mode register selects division by eight or sixteen.
// - Clock-source field selects first or second timer as baud source.
// - Pin-group bit routes transmit and receive to group A or B.
// - Serial output drives the transmit pin whenever output enable is set, except in single-pin mode with the direction bit clear.
// - With input enable clear the internal serial input reads constant one.
// - Two-pin reception takes input from the dedicated receive pin.
// - Single-pin reception takes input from the transmit pin set as input.
// - Single-pin mode releases the receive pin to general port use.
// - Full duplex with both enables lets both directions run together.
// - Writing the transmit buffer starts a frame; completion raises an interrupt.
// - Single-pin mode switches direction by the transmit pin direction bit.
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_map.svh"
module uart_baud_and_pin_routing
  import uart_baud_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txLineAIn,
  input wire logic txLineBIn,
  input wire logic rxLineA,
  input wire logic rxLineB,
  output logic txLineA,
  output logic txLineAOe,
  output logic txLineB,
  output logic txLineBOe,
  output logic rxPortReleased,
  output logic txBusy,
  output logic irq
);
  serial_cfg_t cfg_reg;
  logic [7:0] compareA_reg;
  logic [7:0] compareB_reg;
  logic [7:0] prescale_reg;
  logic [1:0] portDir_reg;
  logic [7:0] rxBuffer_reg;
  logic [1:0] irqStatus_reg;
  logic [1:0] irqMask_reg;
  xfer_state_t txState_reg;
  xfer_state_t rxState_reg;
  logic [9:0] txShift_reg;
  logic [3:0] txCnt_reg;
  logic [7:0] rxShift_reg;
  logic [3:0] rxCnt_reg;
  logic [4:0] rxPhase_reg;
  logic serialOut_reg;
  logic overflowA;
  logic overflowB;
  logic baudTick;
  logic txBitTick;
  logic rxSampleTick;
  logic serialIn;
  logic rawIn;
  logic txPinIn;
  logic abortAll;
  logic singlePinTx;
  logic wrEn;
  logic rdEn;
  logic txStart;
  logic txDoneEv;
  logic rxDoneEv;
  logic statusRead;

  function automatic logic hitAddr(input logic [11:0] addr, input logic [11:0] ofs);
    hitAddr = (addr == ofs);
  endfunction : hitAddr

  assign wrEn = psel && penable && pwrite;
  // A status read clears at the edge that captures its data, so an event landing on that edge is kept.
  assign rdEn = psel && !penable && !pwrite;
  assign txStart = wrEn && hitAddr(paddr, `OFS_TX_BUFFER) && (txState_reg == XFER_IDLE) && cfg_reg.outputEnable;
  assign statusRead = rdEn && hitAddr(paddr, `OFS_IRQ_STATUS);
  assign abortAll = !cfg_reg.outputEnable && !cfg_reg.inputEnable;

  baud_timer timerA (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .prescale(prescale_reg),
    .compare(compareA_reg),
    .overflow(overflowA)
  );
  baud_timer timerB (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .prescale(prescale_reg),
    .compare(compareB_reg),
    .overflow(overflowB)
  );
  assign baudTick = cfg_reg.srcTimerB ? overflowB : overflowA;
  bit_divider txDiv (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(baudTick),
    .divSixteen(cfg_reg.divSixteen),
    .restart(txStart || abortAll),
    .bitTick(txBitTick)
  );

  // Input routing: group, pin select and the constant one when input is off.
  assign txPinIn = cfg_reg.pinGroupB ? txLineBIn : txLineAIn;
  assign rawIn = cfg_reg.inputPinSelect ? txPinIn : (cfg_reg.pinGroupB ? rxLineB : rxLineA);
  assign serialIn = cfg_reg.inputEnable ? rawIn : 1'b1;
  assign singlePinTx = !cfg_reg.inputPinSelect || portDir_reg[`BIT_DIR_TX_OUT];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_reg <= '0;
      compareA_reg <= `RST_COMPARE;
      compareB_reg <= `RST_COMPARE;
      prescale_reg <= `RST_PRESCALE;
      portDir_reg <= `RST_DIR;
      irqMask_reg <= 2'h0;
    end
    else if (wrEn)
    begin
      if (hitAddr(paddr, `OFS_CLOCK_SOURCE))
        cfg_reg.srcTimerB <= pwdata[`BIT_SRC_TIMER_B];
      if (hitAddr(paddr, `OFS_MODE_ONE))
      begin
        cfg_reg.divSixteen <= pwdata[`BIT_DIV_SIXTEEN];
        cfg_reg.outputEnable <= pwdata[`BIT_OUTPUT_ENABLE];
        cfg_reg.inputEnable <= pwdata[`BIT_INPUT_ENABLE];
        cfg_reg.inputPinSelect <= pwdata[`BIT_INPUT_PIN_SELECT];
      end
      if (hitAddr(paddr, `OFS_PIN_GROUP))
        cfg_reg.pinGroupB <= pwdata[`BIT_PIN_GROUP_B];
      if (hitAddr(paddr, `OFS_TIMER_A_COMPARE))
        compareA_reg <= pwdata[7:0];
      if (hitAddr(paddr, `OFS_TIMER_B_COMPARE))
        compareB_reg <= pwdata[7:0];
      if (hitAddr(paddr, `OFS_PORT_DIRECTION))
        portDir_reg <= pwdata[1:0];
      if (hitAddr(paddr, `OFS_IRQ_MASK))
        irqMask_reg <= pwdata[1:0];
      if (hitAddr(paddr, `OFS_TIMER_PRESCALE))
        prescale_reg <= pwdata[7:0];
    end
  end

  // Transmitter: start bit, eight data bits LSB first, one stop bit.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txState_reg <= XFER_IDLE;
      txShift_reg <= 10'h3ff;
      txCnt_reg <= 4'h0;
      serialOut_reg <= 1'b1;
    end
    else if (abortAll || !cfg_reg.outputEnable)
    begin
      txState_reg <= XFER_IDLE;
      serialOut_reg <= 1'b1;
      txCnt_reg <= 4'h0;
    end
    else
    begin
      case (txState_reg)
        XFER_IDLE:
        begin
          if (txStart)
          begin
            txShift_reg <= {1'b1, pwdata[7:0], 1'b0};
            txCnt_reg <= 4'h0;
            serialOut_reg <= 1'b0;
            txState_reg <= XFER_SHIFT;
          end
        end
        XFER_SHIFT:
        begin
          if (txBitTick)
          begin
            if (txCnt_reg == `FRAME_BITS - 4'h1)
            begin
              serialOut_reg <= 1'b1;
              txState_reg <= XFER_DONE;
            end
            else
            begin
              txCnt_reg <= txCnt_reg + 4'h1;
              serialOut_reg <= txShift_reg[txCnt_reg + 4'h1];
            end
          end
        end
        XFER_DONE:
          txState_reg <= XFER_IDLE;
        default:
          txState_reg <= XFER_IDLE;
      endcase
    end
  end
  assign txDoneEv = (txState_reg == XFER_DONE);

  // Receiver samples each bit at mid-bit using the baud tick phase.
  assign rxSampleTick = baudTick && (rxPhase_reg == (cfg_reg.divSixteen ? 5'h0f : 5'h07));
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxState_reg <= XFER_IDLE;
      rxShift_reg <= 8'h00;
      rxCnt_reg <= 4'h0;
      rxPhase_reg <= 5'h00;
      rxBuffer_reg <= 8'h00;
    end
    else if (!cfg_reg.inputEnable)
    begin
      rxState_reg <= XFER_IDLE;
      rxCnt_reg <= 4'h0;
      rxPhase_reg <= 5'h00;
    end
    else
    begin
      case (rxState_reg)
        XFER_IDLE:
        begin
          rxPhase_reg <= 5'h00;
          rxCnt_reg <= 4'h0;
          if (!serialIn)
            rxState_reg <= XFER_SHIFT;
        end
        XFER_SHIFT:
        begin
          if (baudTick)
            rxPhase_reg <= (rxPhase_reg == (cfg_reg.divSixteen ? 5'h1f : 5'h0f)) ? 5'h00 : rxPhase_reg + 5'h01;
          if (rxSampleTick)
          begin
            if (rxCnt_reg == 4'h0 && serialIn)
              rxState_reg <= XFER_IDLE;
            else if (rxCnt_reg == `FRAME_BITS - 4'h1)
            begin
              rxBuffer_reg <= rxShift_reg;
              rxState_reg <= XFER_DONE;
            end
            else
            begin
              if (rxCnt_reg != 4'h0)
                rxShift_reg <= {serialIn, rxShift_reg[7:1]};
              rxCnt_reg <= rxCnt_reg + 4'h1;
            end
          end
        end
        XFER_DONE:
          rxState_reg <= XFER_IDLE;
        default:
          rxState_reg <= XFER_IDLE;
      endcase
    end
  end
  assign rxDoneEv = (rxState_reg == XFER_DONE);

  // Sticky events; a read clears them but a same-cycle event wins.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irqStatus_reg <= 2'h0;
    else
    begin
      irqStatus_reg[`BIT_IRQ_TX_DONE] <= txDoneEv || (irqStatus_reg[`BIT_IRQ_TX_DONE] && !statusRead);
      irqStatus_reg[`BIT_IRQ_RX_DONE] <= rxDoneEv || (irqStatus_reg[`BIT_IRQ_RX_DONE] && !statusRead);
    end
  end

  // Pin drivers: serial output on the selected group when output is enabled, unless single-pin mode has the direction bit clear.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txLineA <= 1'b1;
      txLineAOe <= 1'b0;
      txLineB <= 1'b1;
      txLineBOe <= 1'b0;
      rxPortReleased <= 1'b0;
      txBusy <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      txLineA <= serialOut_reg;
      txLineB <= serialOut_reg;
      txLineAOe <= cfg_reg.outputEnable && !cfg_reg.pinGroupB && singlePinTx;
      txLineBOe <= cfg_reg.outputEnable && cfg_reg.pinGroupB && singlePinTx;
      rxPortReleased <= cfg_reg.inputPinSelect;
      txBusy <= (txState_reg != XFER_IDLE);
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // APB slave: zero wait states, unmapped addresses answer with an error.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        case (paddr)
          `OFS_CLOCK_SOURCE: prdata <= {31'h0, cfg_reg.srcTimerB};
          `OFS_MODE_ONE: prdata <= {24'h0, cfg_reg.inputPinSelect, 1'b0, cfg_reg.inputEnable,
                                    cfg_reg.outputEnable, 2'h0, cfg_reg.divSixteen, 1'b0};
          `OFS_PIN_GROUP: prdata <= {30'h0, cfg_reg.pinGroupB, 1'b0};
          `OFS_TIMER_A_COMPARE: prdata <= {24'h0, compareA_reg};
          `OFS_TIMER_B_COMPARE: prdata <= {24'h0, compareB_reg};
          `OFS_PORT_DIRECTION: prdata <= {30'h0, portDir_reg};
          `OFS_TX_BUFFER: prdata <= {31'h0, txState_reg != XFER_IDLE};
          `OFS_RX_BUFFER: prdata <= {24'h0, rxBuffer_reg};
          `OFS_IRQ_STATUS: prdata <= {30'h0, irqStatus_reg};
          `OFS_IRQ_MASK: prdata <= {30'h0, irqMask_reg};
          `OFS_TIMER_PRESCALE: prdata <= {24'h0, prescale_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  a_tx_oe_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (txLineAOe || txLineBOe) |-> $past(cfg_reg.outputEnable)) else $error("tx pin driven while output off");
  a_group_excl: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(txLineAOe && txLineBOe)) else $error("both pin groups driven");
  a_abort_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    abortAll |=> txState_reg == XFER_IDLE && rxState_reg == XFER_IDLE) else $error("abort left logic busy");
  a_const_one: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cfg_reg.inputEnable |-> serialIn) else $error("input not one while disabled");
  a_start_tx: assert property (@(posedge clk_sys) disable iff (!arst_n)
    txStart |=> txState_reg == XFER_SHIFT && !serialOut_reg) else $error("write did not start frame");
  a_done_irq: assert property (@(posedge clk_sys) disable iff (!arst_n)
    txDoneEv |=> irqStatus_reg[0]) else $error("tx done not flagged");
  a_single_dir: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_reg.inputPinSelect && !portDir_reg[0]) |=> !txLineAOe && !txLineBOe) else $error("shared pin driven");
  a_src_sel: assert property (@(posedge clk_sys) disable iff (!arst_n)
    txBitTick |-> $past(cfg_reg.srcTimerB ? overflowB : overflowA)) else $error("bit tick without source tick");
  a_div_spacing: assert property (@(posedge clk_sys) disable iff (!arst_n)
    txBitTick |=> !txBitTick) else $error("bit tick too close");
  c_tx_frame: cover property (@(posedge clk_sys) disable iff (!arst_n) txDoneEv);
  c_rx_frame: cover property (@(posedge clk_sys) disable iff (!arst_n) rxDoneEv);
  c_duplex: cover property (@(posedge clk_sys) disable iff (!arst_n)
    txState_reg == XFER_SHIFT && rxState_reg == XFER_SHIFT);
endmodule : uart_baud_and_pin_routing
`default_nettype wire

// >>> include/uart_baud_map.svh
// Register offsets, field positions, reset values and timing counts of the serial baud and pin block.
`ifndef UART_BAUD_MAP_SVH
`define UART_BAUD_MAP_SVH
`define OFS_CLOCK_SOURCE 12'h000
`define OFS_MODE_ONE 12'h004
`define OFS_PIN_GROUP 12'h008
`define OFS_TIMER_A_COMPARE 12'h00c
`define OFS_TIMER_B_COMPARE 12'h010
`define OFS_PORT_DIRECTION 12'h014
`define OFS_TX_BUFFER 12'h018
`define OFS_RX_BUFFER 12'h01c
`define OFS_IRQ_STATUS 12'h020
`define OFS_IRQ_MASK 12'h024
`define OFS_TIMER_PRESCALE 12'h028
`define BIT_SRC_TIMER_B 0
`define BIT_DIV_SIXTEEN 1
`define BIT_OUTPUT_ENABLE 4
`define BIT_INPUT_ENABLE 5
`define BIT_INPUT_PIN_SELECT 7
`define BIT_PIN_GROUP_B 1
`define BIT_DIR_TX_OUT 0
`define BIT_DIR_RX_OUT 1
`define BIT_IRQ_TX_DONE 0
`define BIT_IRQ_RX_DONE 1
`define RST_COMPARE 8'hcf
`define RST_PRESCALE 8'h00
`define RST_DIR 2'h0
`define FRAME_BITS 4'ha
`endif

// >>> include/uart_baud_pkg.sv
// Types shared by the serial baud and pin block.
package uart_baud_pkg;
  typedef struct packed {
    logic srcTimerB;
    logic divSixteen;
    logic outputEnable;
    logic inputEnable;
    logic inputPinSelect;
    logic pinGroupB;
  } serial_cfg_t;
  typedef struct packed {
    logic txA;
    logic txAOe;
    logic txB;
    logic txBOe;
  } pin_drive_t;
  typedef enum logic [2:0] {
    XFER_IDLE = 3'b001,
    XFER_SHIFT = 3'b010,
    XFER_DONE = 3'b100
  } xfer_state_t;
endpackage : uart_baud_pkg

// >>> design/baud_timer.sv
// Compare timer that produces a periodic overflow tick.
`timescale 1ns/1ps
`default_nettype none
module baud_timer
  import uart_baud_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] prescale,
  input wire logic [7:0] compare,
  output logic overflow
);
  logic [7:0] preCnt_reg;
  logic [7:0] cnt_reg;
  logic timerClk;
  assign timerClk = (preCnt_reg == prescale);
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      preCnt_reg <= 8'h00;
    else if (timerClk)
      preCnt_reg <= 8'h00;
    else
      preCnt_reg <= preCnt_reg + 8'h01;
  end
  // Count from zero and restart when the count reaches or exceeds the compare value.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 8'h00;
      overflow <= 1'b0;
    end
    else
    begin
      overflow <= 1'b0;
      if (timerClk)
      begin
        if (cnt_reg >= compare)
        begin
          cnt_reg <= 8'h00;
          overflow <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule : baud_timer
`default_nettype wire

// >>> design/bit_divider.sv
// Divides the selected timer overflow by two and by eight or sixteen.
`timescale 1ns/1ps
`default_nettype none
module bit_divider
  import uart_baud_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic divSixteen,
  input wire logic restart,
  output logic bitTick
);
  logic [4:0] cnt_reg;
  logic [4:0] last;
  assign last = divSixteen ? 5'h1f : 5'h0f;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 5'h00;
      bitTick <= 1'b0;
    end
    else
    begin
      bitTick <= 1'b0;
      if (restart)
        cnt_reg <= 5'h00;
      else if (tick)
      begin
        if (cnt_reg >= last)
        begin
          cnt_reg <= 5'h00;
          bitTick <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end
endmodule : bit_divider
`default_nettype wire

// >>> testbench/serial_peer_model.sv
// Remote serial transceiver that frames bytes onto lineOut and unframes bytes from lineIn.
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model
(
  input wire logic clk_sys,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'b1;
  // Sends a start bit, eight data bits lowest first and a stop bit.
  task automatic sendByte(input logic [7:0] d, input int p);
    logic [9:0] f;
    begin
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        lineOut <= f[i];
        repeat (p) @(posedge clk_sys);
      end
    end
  endtask : sendByte
  // Skips the start bit, whose length follows the timer phase, and times bit 0 instead.
  // The sender keeps bit 0 high and bit 1 low, so bit 0 spans one whole bit period.
  task automatic catchFrame(output logic [7:0] d, output int w);
    int n;
    begin
      d = 8'h01;
      w = 0;
      n = 0;
      @(posedge clk_sys);
      while (lineIn !== 1'b0 && n < 100)
      begin
        @(posedge clk_sys);
        n++;
      end
      while (lineIn === 1'b0 && n < 5000)
      begin
        @(posedge clk_sys);
        n++;
      end
      while (lineIn === 1'b1 && w < 5000)
      begin
        w++;
        @(posedge clk_sys);
      end
      for (int i = 1; i < 8; i++)
      begin
        repeat (w / 2) @(posedge clk_sys);
        d[i] = lineIn;
        repeat (w - w / 2) @(posedge clk_sys);
      end
    end
  endtask : catchFrame
endmodule : serial_peer_model
`default_nettype wire

// >>> testbench/uart_baud_and_pin_routing_tb_top.sv
// Self-checking bench for the serial baud and pin block.
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_map.svh"
module uart_baud_and_pin_routing_tb_top
  import uart_baud_pkg::*;
;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic txLineA, txLineAOe, txLineB, txLineBOe, rxPortReleased, txBusy, irq;
  logic grpB, single, peerOut, txPinA, txPinB, rxLineA, rxLineB, peerIn;
  logic [7:0] sent, got, rxByte;
  int miscompares, comparisons, per, wid;
  int seed = 94719;
  assign txPinA = txLineAOe ? txLineA : ((!grpB && single) ? peerOut : 1'b1);
  assign txPinB = txLineBOe ? txLineB : ((grpB && single) ? peerOut : 1'b1);
  assign rxLineA = (!grpB && !single) ? peerOut : 1'b1;
  assign rxLineB = (grpB && !single) ? peerOut : 1'b1;
  assign peerIn = grpB ? txPinB : txPinA;
  uart_baud_and_pin_routing dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txLineAIn(txPinA), .txLineBIn(txPinB), .rxLineA(rxLineA), .rxLineB(rxLineB), .txLineA(txLineA),
    .txLineAOe(txLineAOe), .txLineB(txLineB), .txLineBOe(txLineBOe), .rxPortReleased(rxPortReleased),
    .txBusy(txBusy), .irq(irq));
  serial_peer_model peer (.clk_sys(clk_sys), .lineIn(peerIn), .lineOut(peerOut));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    begin
      if (miscompares == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask : check
  // One register transfer: setup cycle, then access until ready.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    begin
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50)
      begin
        @(posedge clk_sys);
        n++;
      end
      if (pready !== 1'b1)
        miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : apb
  function automatic int expPeriod(input int cmp, input int pre, input logic div16);
    return (cmp + 1) * (pre + 1) * 2 * (div16 ? 16 : 8);
  endfunction : expPeriod
  task automatic setMode(input logic div, input logic oe, input logic ie, input logic sel);
    begin
      apb(`OFS_MODE_ONE, 1'b1, {24'h0, sel, 1'b0, ie, oe, 2'b0, div, 1'b0});
    end
  endtask : setMode
  task automatic setRate(input logic src, input logic div);
    int cmp;
    begin
      cmp = div ? 6 + {$random(seed)} % 2 : 13 + {$random(seed)} % 2;
      apb(`OFS_TIMER_PRESCALE, 1'b1, 32'h3);
      apb(src ? `OFS_TIMER_B_COMPARE : `OFS_TIMER_A_COMPARE, 1'b1, 32'(cmp));
      apb(src ? `OFS_TIMER_A_COMPARE : `OFS_TIMER_B_COMPARE, 1'b1, 32'h30);
      apb(`OFS_CLOCK_SOURCE, 1'b1, {31'h0, src});
      per = expPeriod(cmp, 3, div);
    end
  endtask : setRate
  task automatic setGroup(input logic g);
    begin
      grpB <= g;
      apb(`OFS_PIN_GROUP, 1'b1, {30'h0, g, 1'b0});
    end
  endtask : setGroup
  task automatic waitIdle;
    int n;
    begin
      n = 0;
      while (txBusy !== 1'b0 && n < 5000)
      begin
        @(posedge clk_sys);
        n++;
      end
      check({31'h0, txBusy}, 32'h0);
      repeat (3) @(posedge clk_sys);
    end
  endtask : waitIdle
  initial
  begin
    repeat (95000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
  initial
  begin
    arst_n = 1'b0;
    {psel, penable, pwrite, grpB, single} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    apb(`OFS_TIMER_A_COMPARE, 1'b0, 32'h0);
    check(rd, {24'h0, `RST_COMPARE});
    apb(`OFS_TIMER_B_COMPARE, 1'b0, 32'h0);
    check(rd, {24'h0, `RST_COMPARE});
    apb(`OFS_TIMER_PRESCALE, 1'b0, 32'h0);
    check(rd, 32'h0);
    apb(12'hffc, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    // Every timer source and divider, with the interrupt masked and unmasked.
    for (int i = 0; i < 4; i++)
    begin
      setGroup(1'($random(seed)));
      setRate(i[0], i[1]);
      apb(`OFS_PORT_DIRECTION, 1'b1, 32'h1);
      setMode(i[1], 1'b1, 1'b0, 1'b0);
      apb(`OFS_IRQ_MASK, 1'b1, {31'h0, i[0]});
      sent = (8'($random(seed)) | 8'h01) & 8'hfd;
      fork
        peer.catchFrame(got, wid);
        apb(`OFS_TX_BUFFER, 1'b1, {24'h0, sent});
      join
      check(32'(wid), 32'(per));
      check({24'h0, got}, {24'h0, sent});
      check({30'h0, txLineAOe, txLineBOe}, {30'h0, !grpB, grpB});
      waitIdle();
      check({31'h0, irq}, {31'h0, i[0]});
      apb(`OFS_IRQ_STATUS, 1'b0, 32'h0);
      check(rd, 32'h1);
      apb(`OFS_IRQ_STATUS, 1'b0, 32'h0);
      check({rd[30:0], irq}, 32'h0);
    end
    // Both directions at once on two pins.
    setGroup(1'b0);
    setRate(1'b0, 1'b0);
    setMode(1'b0, 1'b1, 1'b1, 1'b0);
    check({31'h0, rxPortReleased}, 32'h0);
    sent = (8'($random(seed)) | 8'h01) & 8'hfd;
    rxByte = 8'($random(seed));
    fork
      peer.catchFrame(got, wid);
      peer.sendByte(rxByte, per);
      apb(`OFS_TX_BUFFER, 1'b1, {24'h0, sent});
    join
    check({24'h0, got}, {24'h0, sent});
    waitIdle();
    apb(`OFS_RX_BUFFER, 1'b0, 32'h0);
    check(rd, {24'h0, rxByte});
    apb(`OFS_IRQ_STATUS, 1'b0, 32'h0);
    check(rd, 32'h3);
    // One shared pin on group B, direction switched by the port bit.
    setGroup(1'b1);
    setRate(1'b1, 1'b1);
    single <= 1'b1;
    setMode(1'b1, 1'b1, 1'b1, 1'b1);
    apb(`OFS_PORT_DIRECTION, 1'b1, 32'h1);
    repeat (3) @(posedge clk_sys);
    check({31'h0, txLineBOe}, 32'h1);
    apb(`OFS_PORT_DIRECTION, 1'b1, 32'h0);
    repeat (3) @(posedge clk_sys);
    check({30'h0, rxPortReleased, txLineBOe}, 32'h2);
    rxByte = 8'($random(seed));
    peer.sendByte(rxByte, per);
    repeat (20) @(posedge clk_sys);
    apb(`OFS_RX_BUFFER, 1'b0, 32'h0);
    check(rd, {24'h0, rxByte});
    apb(`OFS_IRQ_STATUS, 1'b0, 32'h0);
    check(rd, 32'h2);
    // Input disabled: a frame on the receive pin is not seen.
    single <= 1'b0;
    setGroup(1'b0);
    apb(`OFS_PORT_DIRECTION, 1'b1, 32'h1);
    setMode(1'b0, 1'b1, 1'b0, 1'b0);
    peer.sendByte(8'h00, per);
    repeat (20) @(posedge clk_sys);
    apb(`OFS_IRQ_STATUS, 1'b0, 32'h0);
    check(rd, 32'h0);
    // Clearing both enables in mid-frame stops the transfer.
    setMode(1'b0, 1'b1, 1'b1, 1'b0);
    apb(`OFS_TX_BUFFER, 1'b1, 32'h0);
    repeat (100) @(posedge clk_sys);
    check({31'h0, txBusy}, 32'h1);
    setMode(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check({30'h0, txBusy, txLineA}, 32'h1);
    apb(`OFS_TX_BUFFER, 1'b0, 32'h0);
    check(rd, 32'h0);
    summarize();
  end
endmodule : uart_baud_and_pin_routing_tb_top
`default_nettype wire
